// [core/ldui_pkg.sv]
// Constants, types and helper functions for the LED dimming update-interval block.
// Assumes one dimming clock and a plain register port on the same clock.
//
// Behaviour
// RULE_01 - Apply new duty every 1..32 periods by code.
// RULE_02 - Codes 6 and 7 act like code 5.
// RULE_03 - Default PWM period is 8,192 dimming clocks.
// RULE_04 - Global config bits 3:2 choose period length.
// RULE_05 - Register 0x34 holds LED10 to LED12 codes.
// RULE_06 - LED8 code sits in bits 6:4.
// RULE_07 - LED7 code sits in bits 2:0.
// RULE_08 - Group A register broadcasts duty and enable.
// RULE_09 - Group A write copies into member channels.
// RULE_10 - Duty 0 is off, 0xfff is full on.
// RULE_11 - Count periods, load at interval, then restart.
package ldui_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int N_CH = 6;
    localparam int DUTY_W = 12;
    localparam int CODE_W = 3;
    localparam int PCNT_W = 5;

    localparam logic [7:0] ADDR_GLOBAL_CFG = 8'h02;
    localparam logic [7:0] ADDR_INTERVAL_LO = 8'h33;
    localparam logic [7:0] ADDR_INTERVAL_HI = 8'h34;
    localparam logic [7:0] ADDR_GROUP_A = 8'h40;
    localparam logic [7:0] ADDR_DUTY_LED1 = 8'h42;
    localparam logic [7:0] FIRST_LED_NUM = 8'h07;
    localparam logic [7:0] ADDR_GROUP_A_MEMBERS = 8'h50;
    localparam logic [7:0] ADDR_PWM_STATUS = 8'h51;

    localparam int PERIOD_SEL_LSB = 2;
    localparam int PERIOD_SEL_W = 2;
    localparam int FADE_BIT = 12;
    localparam int FIELD_STRIDE = 4;
    localparam int CH_PER_REG = 3;

    localparam int PWM_PERIOD_DEFAULT = 8192;
    localparam logic [1:0] PERIOD_SEL_RESET = 2'h0;
    localparam logic [10:0] INTERVAL_RESET = 11'h000;
    localparam logic [5:0] MEMBERS_RESET = 6'h00;
    localparam logic [11:0] DUTY_OFF = 12'h000;
    localparam logic [11:0] DUTY_FULL = 12'hfff;
    localparam logic [2:0] CODE_SATURATE = 3'h5;
    localparam logic [4:0] LAST_PERIOD_MAX = 5'h1f;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic fade;
        logic [DUTY_W-1:0] duty;
    } ldui_duty_t;

    localparam ldui_duty_t DUTY_RESET = '{fade: 1'b0, duty: 12'h000};

    // Index of the last period of an interval: 2**code - 1, saturating at 31.
    function automatic logic [PCNT_W-1:0] ldui_interval_last(input logic [CODE_W-1:0] code);
        logic [PCNT_W-1:0] last;
        last = LAST_PERIOD_MAX;
        if (code < CODE_SATURATE) begin
            last = PCNT_W'((6'h01 << code) - 6'h01);
        end
        return last;
    endfunction : ldui_interval_last

endpackage : ldui_pkg

// [core/ldui_channel.sv]
// One dimming channel: pending duty, period counter, applied duty and PWM output.
// Assumes the top supplies a one-cycle period-end pulse and a 12-bit phase.
`timescale 1ns/1ps
module ldui_channel
    import ldui_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_period_end,
    input wire logic [DUTY_W-1:0] i_phase,
    input wire logic [CODE_W-1:0] i_code,
    input wire logic i_load,
    input wire ldui_duty_t i_load_val,
    output ldui_duty_t o_pending,
    output ldui_duty_t o_applied,
    output logic o_pwm
);

    ////////////////////////////////////////////////////////////////////////////////
    ldui_duty_t pending;
    ldui_duty_t applied;
    logic [PCNT_W-1:0] pcnt;
    logic pwm;

    wire logic [PCNT_W-1:0] last = ldui_interval_last(i_code); // RULE_01 RULE_02
    // A shortened code may leave the count above the new last; treat that as due.
    wire logic due = i_period_end && (pcnt >= last); // RULE_11
    wire logic next_pwm = applied.fade && (applied.duty != DUTY_OFF)
        && ((applied.duty == DUTY_FULL) || (applied.duty > i_phase)); // RULE_10

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pending <= DUTY_RESET;
        end else if (i_ce && i_load) begin
            pending <= i_load_val;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            applied <= DUTY_RESET;
            pcnt <= '0;
        end else if (i_ce && due) begin
            applied <= pending; // RULE_01
            pcnt <= '0; // RULE_11
        end else if (i_ce && i_period_end) begin
            pcnt <= pcnt + 5'h01; // RULE_11
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pwm <= 1'b0;
        end else if (i_ce) begin
            pwm <= next_pwm;
        end
    end

    assign o_pending = pending;
    assign o_applied = applied;
    assign o_pwm = pwm;

    ////////////////////////////////////////////////////////////////////////////////
    a_apply_at_due: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_01
        (i_ce && i_period_end && pcnt == last) |=> (applied == $past(pending)))
        else $error("Pending duty not applied at interval end.");

    a_code_saturates: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_02
        (i_code >= 3'h5) |-> (last == 5'h1f))
        else $error("Interval code above 5 does not give 32 periods.");

    a_apply_only_due: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_11
        (applied != $past(applied)) |-> $past(i_ce && i_period_end && pcnt >= last))
        else $error("Applied duty changed away from an interval end.");

    a_count_restart: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_11
        (i_ce && due) |=> (pcnt == 5'h00))
        else $error("Period count did not restart after loading.");

    a_duty_off: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_10
        (i_ce && applied.duty == 12'h000) |=> !pwm)
        else $error("Duty zero left the output on.");

    a_duty_full: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_10
        (i_ce && applied.fade && applied.duty == 12'hfff) |=> pwm)
        else $error("Full duty did not hold the output on.");

endmodule : ldui_channel

// [core/ldui_top.sv]
// Register file, PWM period timing and the six dimming channels LED7 to LED12.
// Assumes the register master runs on I_MCLK and issues one-cycle strobes.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module ldui_top
    import ldui_pkg::*;
#(
    parameter int PWM_PERIOD_CYC = PWM_PERIOD_DEFAULT
) (
    input wire logic I_MCLK,
    input wire logic I_NRST,
    input wire logic I_CE,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [DATA_W-1:0] O_RDATA,
    output logic [N_CH-1:0] O_PWM
);

    ////////////////////////////////////////////////////////////////////////////////
    // The period must be a power of two so that the phase is a plain shift.
    localparam int PER_W = $clog2(PWM_PERIOD_CYC);
    localparam logic [PER_W-1:0] PERIOD_LAST = PER_W'(PWM_PERIOD_CYC - 1);

    logic [PERIOD_SEL_W-1:0] period_sel;
    logic [10:0] interval_lo;
    logic [10:0] interval_hi;
    ldui_duty_t group_a;
    logic [N_CH-1:0] members;
    logic [PER_W-1:0] pcount;
    logic [DATA_W-1:0] rdata;
    ldui_duty_t pending [N_CH];
    ldui_duty_t applied [N_CH];
    logic [N_CH-1:0] pwm;

    ////////////////////////////////////////////////////////////////////////////////
    wire logic wr_cfg = I_WR && (I_ADDR == ADDR_GLOBAL_CFG);
    wire logic wr_int_lo = I_WR && (I_ADDR == ADDR_INTERVAL_LO);
    wire logic wr_int_hi = I_WR && (I_ADDR == ADDR_INTERVAL_HI);
    wire logic wr_grp = I_WR && (I_ADDR == ADDR_GROUP_A);
    wire logic wr_members = I_WR && (I_ADDR == ADDR_GROUP_A_MEMBERS);
    wire logic [ADDR_W-1:0] duty_base = ADDR_DUTY_LED1 + FIRST_LED_NUM - 8'h01;
    wire logic [ADDR_W-1:0] duty_idx = I_ADDR - duty_base;
    wire logic duty_hit = (I_ADDR >= duty_base) && (duty_idx < ADDR_W'(N_CH));
    wire logic [10:0] int_mask = 11'h777;

    // Shorter periods halve the count end for each step of the select field.
    wire logic [PER_W-1:0] period_last = PERIOD_LAST >> period_sel; // RULE_03 RULE_04
    wire logic period_end = (pcount >= period_last);
    wire logic [31:0] phase_wide = (32'(pcount) << (12 + period_sel)) >> PER_W;
    wire logic [DUTY_W-1:0] phase = phase_wide[DUTY_W-1:0];
    wire logic [21:0] intervals = {interval_hi, interval_lo};

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            pcount <= '0;
        end else if (I_CE) begin
            pcount <= period_end ? '0 : pcount + PER_W'(1); // RULE_03
        end
    end

    // Reserved bits are masked on write, so reads return zero there.
    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            period_sel <= PERIOD_SEL_RESET;
            interval_lo <= INTERVAL_RESET;
            interval_hi <= INTERVAL_RESET;
            group_a <= DUTY_RESET;
            members <= MEMBERS_RESET;
        end else if (I_CE) begin
            if (wr_cfg) begin
                period_sel <= I_WDATA[PERIOD_SEL_LSB +: PERIOD_SEL_W]; // RULE_04
            end
            if (wr_int_lo) begin
                interval_lo <= I_WDATA[10:0] & int_mask; // RULE_06 RULE_07
            end
            if (wr_int_hi) begin
                interval_hi <= I_WDATA[10:0] & int_mask; // RULE_05
            end
            if (wr_grp) begin
                group_a <= I_WDATA[FADE_BIT:0]; // RULE_08
            end
            if (wr_members) begin
                members <= I_WDATA[N_CH-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel j serves LED7 plus j; within a register each code field is four bits above the one before.
    genvar j;
    generate
        for (j = 0; j < N_CH; j++) begin : g_ch
            localparam int REG_SEL = j / CH_PER_REG;
            localparam int POS = REG_SEL * 11 + (j % CH_PER_REG) * FIELD_STRIDE;
            wire logic [CODE_W-1:0] code = intervals[POS +: CODE_W]; // RULE_05 RULE_06 RULE_07
            wire logic wr_own = I_WR && duty_hit && (duty_idx == ADDR_W'(j));
            // Both sources carry the same write word, so only the strobe differs.
            wire logic load = wr_own || (wr_grp && members[j]); // RULE_09
            ldui_channel u_ch (
                .i_clk(I_MCLK),
                .i_nrst(I_NRST),
                .i_ce(I_CE),
                .i_period_end(period_end),
                .i_phase(phase),
                .i_code(code),
                .i_load(load),
                .i_load_val(I_WDATA[FADE_BIT:0]),
                .o_pending(pending[j]),
                .o_applied(applied[j]),
                .o_pwm(pwm[j])
            );

            a_group_copy: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_09
                (I_CE && wr_grp && members[j]) |=> (pending[j] == $past(I_WDATA[12:0])))
                else $error("Group write missed a member channel.");

            // A disabled channel must stay dark whatever duty it holds.
            a_pwm_disabled: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_08
                (I_CE && !applied[j].fade) |=> !O_PWM[j])
                else $error("Disabled channel drove its output.");

            a_own_write: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
                (I_CE && I_WR && I_ADDR == duty_base + 8'(j)) |=> (pending[j] == $past(I_WDATA[12:0])))
                else $error("Own duty write missed its channel.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Unused addresses read as zero so software can probe the map safely.
    wire ldui_duty_t duty_rd = pending[duty_idx[2:0]];
    wire logic [DATA_W-1:0] rd_mux =
        (I_ADDR == ADDR_GLOBAL_CFG) ? DATA_W'({period_sel, 2'b00}) :
        (I_ADDR == ADDR_INTERVAL_LO) ? DATA_W'(interval_lo) :
        (I_ADDR == ADDR_INTERVAL_HI) ? DATA_W'(interval_hi) :
        (I_ADDR == ADDR_GROUP_A) ? DATA_W'(group_a) :
        (I_ADDR == ADDR_GROUP_A_MEMBERS) ? DATA_W'(members) :
        (I_ADDR == ADDR_PWM_STATUS) ? DATA_W'(pwm) :
        duty_hit ? DATA_W'(duty_rd) : 16'h0000;

    // Read data stand in the cycle after the strobe and hold while I_CE is low; zero otherwise.
    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            rdata <= 16'h0000;
        end else if (I_CE) begin
            rdata <= I_RD ? rd_mux : 16'h0000;
        end
    end

    assign O_RDATA = rdata;
    assign O_PWM = pwm;

    ////////////////////////////////////////////////////////////////////////////////
    a_period_len: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_03
        (I_CE && period_sel == 2'h0 && period_end) |-> (32'(pcount) == PWM_PERIOD_CYC - 1))
        else $error("Default PWM period has the wrong length.");

    a_period_sel: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_04
        (I_CE && wr_cfg) |=> (period_sel == $past(I_WDATA[3:2])))
        else $error("Period select not taken from bits 3:2.");

    a_int_hi_reg: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_05
        (I_CE && wr_int_hi) ##1 (I_CE && I_RD && I_ADDR == 8'h34)
        |=> (O_RDATA == ($past(I_WDATA, 2) & 16'h0777)))
        else $error("LED10 to LED12 codes do not read back.");

    a_led8_field: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_06
        (I_CE && wr_int_lo) |=> (g_ch[1].code == $past(I_WDATA[6:4])))
        else $error("LED8 code not taken from bits 6:4.");

    a_led7_field: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_07
        (I_CE && wr_int_lo) |=> (g_ch[0].code == $past(I_WDATA[2:0])))
        else $error("LED7 code not taken from bits 2:0.");

    a_group_reg: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_08
        (I_CE && wr_grp) ##1 (I_CE && I_RD && I_ADDR == 8'h40)
        |=> (O_RDATA == {3'b000, $past(I_WDATA[12:0], 2)}))
        else $error("Group duty register does not read back.");

    a_rdata_one_cycle: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (I_CE && !I_RD) |=> (O_RDATA == 16'h0000))
        else $error("Read data stood without a read.");

    a_int_lo_reg: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_06 RULE_07
        (I_CE && wr_int_lo) ##1 (I_CE && I_RD && I_ADDR == 8'h33)
        |=> (O_RDATA == ($past(I_WDATA, 2) & 16'h0777)))
        else $error("LED7 to LED9 codes do not read back.");

    // The end pulse is one cycle long; a longer pulse would skip interval counts.
    a_period_pulse: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_03
        (I_CE && period_end) |=> !period_end)
        else $error("Period end lasted more than one cycle.");

    a_led12_field: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_05
        (I_CE && wr_int_hi) |=> (g_ch[5].code == $past(I_WDATA[10:8])))
        else $error("LED12 code not taken from bits 10:8.");

    a_led10_field: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_05
        (I_CE && wr_int_hi) |=> (g_ch[3].code == $past(I_WDATA[2:0])))
        else $error("LED10 code not taken from bits 2:0.");

    a_members_reg: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_09
        (I_CE && wr_members) |=> (members == $past(I_WDATA[5:0])))
        else $error("Group membership not taken from the write.");

    a_status_read: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (I_CE && I_RD && I_ADDR == 8'h51) |=> (O_RDATA == 16'($past(O_PWM))))
        else $error("Status read does not show the outputs.");

    // Holding state while the enable is low lets a slow master pace the block.
    a_ce_freeze: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (!I_CE) |=> ($stable(pcount) && $stable(O_RDATA) && $stable(O_PWM)))
        else $error("State moved while the clock enable was low.");

    // Reads of an unused address must not leak another register.
    a_unmapped_read: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (I_CE && I_RD && I_ADDR == 8'h7f) |=> (O_RDATA == 16'h0000))
        else $error("Unused address returned data.");

    a_cfg_read: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // RULE_04
        (I_CE && I_RD && I_ADDR == 8'h02) |=> (O_RDATA == {12'h000, $past(period_sel), 2'b00}))
        else $error("Period select does not read back in bits 3:2.");

endmodule : ldui_top

// [sim/ldui_top_tb.sv]
// Self-checking bench for ldui_top: register model, update intervals, duty shape, group A.
// Assumes a 64-cycle PWM period and a register master on the block's own clock.
`timescale 1ns/1ps
module ldui_top_tb;
    import ldui_pkg::*;
    localparam int PER = 64;
    logic I_MCLK, I_NRST, I_CE, I_WR, I_RD;
    logic [ADDR_W-1:0] I_ADDR;
    logic [DATA_W-1:0] I_WDATA, O_RDATA, v;
    logic [N_CH-1:0] O_PWM, mem;
    int fails, num_checks, cyc, t0, n, ch, sel, code, nper;
    logic [15:0] regm [int];
    int addrs [8] = '{8'h02, 8'h33, 8'h34, 8'h40, 8'h48, 8'h4d, 8'h50, 8'h7f};
    logic [31:0] shape [5] = '{32'h0020_1800, 32'h0001_1001, 32'h0040_1fff, 32'h0000_1000,
        32'h0000_0fff};

    ldui_top #(.PWM_PERIOD_CYC(PER)) dut (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_CE(I_CE),
        .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
        .O_PWM(O_PWM));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        I_MCLK = 1'b0;
        forever #2.5 I_MCLK = ~I_MCLK;
    end

    always @(posedge I_MCLK) cyc <= cyc + 1;

    // Bits outside the documented fields read as zero.
    function automatic logic [15:0] mask_of(input int a);
        if (a == 8'h02) return 16'h000c;
        if (a == 8'h33 || a == 8'h34) return 16'h0777;
        if (a == 8'h40 || (a >= 8'h48 && a <= 8'h4d)) return 16'h1fff;
        if (a == 8'h50) return 16'h003f;
        return 16'h0000;
    endfunction : mask_of

    function automatic logic [15:0] get(input int a);
        return regm.exists(a) ? regm[a] : 16'h0000;
    endfunction : get

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One accepted write, with the copy into every group member's duty.
    function automatic void mdl(input int a, input logic [15:0] d);
        logic [15:0] m;
        m = get(8'h50);
        regm[a] = d & mask_of(a);
        for (int k = 0; k < N_CH; k++) begin
            if (a == 8'h40 && m[k]) regm[8'h48 + k] = d & 16'h1fff;
        end
    endfunction : mdl

    // The model follows a write only if the clock enable let the design take it.
    task automatic wr(input int a, input logic [15:0] d);
        @(posedge I_MCLK);
        I_WR <= 1'b1;
        I_ADDR <= a[7:0];
        I_WDATA <= d;
        @(posedge I_MCLK);
        I_WR <= 1'b0;
        if (I_CE === 1'b1) mdl(a, d);
    endtask : wr

    // Write, read the same address in the very next cycle, then see the data drop.
    task automatic wrrd(input int a, input logic [15:0] d);
        @(posedge I_MCLK);
        I_WR <= 1'b1;
        I_ADDR <= a[7:0];
        I_WDATA <= d;
        @(posedge I_MCLK);
        I_WR <= 1'b0;
        I_RD <= 1'b1;
        mdl(a, d);
        @(posedge I_MCLK);
        I_RD <= 1'b0;
        #1 chk(O_RDATA, get(a));
        @(posedge I_MCLK);
        #1 chk(O_RDATA, 16'h0000);
    endtask : wrrd

    task automatic rd(input int a, output logic [15:0] d);
        @(posedge I_MCLK);
        I_RD <= 1'b1;
        I_ADDR <= a[7:0];
        @(posedge I_MCLK);
        I_RD <= 1'b0;
        #1 d = O_RDATA;
    endtask : rd

    task automatic rdc(input int a);
        rd(a, v);
        chk(v, get(a));
    endtask : rdc

    // Bounded wait for one PWM output to reach a level; the limit covers 32 long periods.
    task automatic wait_pwm(input int c, input logic lvl);
        #1 n = 0;
        while (O_PWM[c] !== lvl && n < 70 * PER) begin
            @(posedge I_MCLK);
            #1 n++;
        end
        if (n >= 70 * PER) chk(16'h0000, 16'h0001);
    endtask : wait_pwm

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge I_MCLK);
        fails++;
        wrap_up();
    end

    initial begin
        I_NRST = 1'b0;
        I_CE = 1'b1;
        I_WR = 1'b0;
        I_RD = 1'b0;
        I_ADDR = '0;
        I_WDATA = '0;
        fails = 0;
        num_checks = 0;
        cyc = 0;
        void'($urandom(59977));
        repeat (8) @(posedge I_MCLK);
        I_NRST <= 1'b1;
        foreach (addrs[i]) rdc(addrs[i]);
        for (int r = 0; r < 3; r++) begin
            foreach (addrs[i]) begin
                wr(addrs[i], 16'($urandom));
                rdc(addrs[i]);
            end
        end
        wrrd(8'h33, 16'($urandom));
        wrrd(8'h34, 16'($urandom));
        wrrd(8'h40, 16'($urandom));
        @(posedge I_MCLK);
        I_CE <= 1'b0;
        wr(8'h34, 16'h0555);
        I_CE <= 1'b1;
        rdc(8'h34);
        // A second reset in mid-run clears the random contents again.
        @(posedge I_MCLK);
        I_NRST <= 1'b0;
        repeat (2) @(posedge I_MCLK);
        I_NRST <= 1'b1;
        regm.delete();
        #1 chk(16'(O_PWM), 16'h0000);
        foreach (addrs[i]) rdc(addrs[i]);
        $display("test registers done");
        // Time from one applied duty to the next is exactly interval times period.
        for (int i = 0; i < 11; i++) begin
            ch = i % N_CH;
            code = i % 8;
            sel = (i < 8) ? 0 : i - 7;
            nper = ((code >= 5) ? 32 : (1 << code)) * (PER >> sel);
            wr(8'h02, 16'(sel << 2));
            wr((ch < 3) ? 8'h33 : 8'h34, 16'(code << (4 * (ch % 3))));
            wr(8'h48 + ch, 16'h1fff);
            wait_pwm(ch, 1'b1);
            t0 = cyc;
            wr(8'h48 + ch, 16'h1000);
            wait_pwm(ch, 1'b0);
            chk(16'(cyc - t0), 16'(nper));
        end
        $display("test intervals done");
        wr(8'h02, 16'h0000);
        wr(8'h33, 16'h0000);
        foreach (shape[i]) begin
            wr(8'h48, shape[i][15:0]);
            repeat (3 * PER) @(posedge I_MCLK);
            n = 0;
            repeat (PER) begin
                @(posedge I_MCLK);
                #1 n += int'(O_PWM[0]);
            end
            chk(16'(n), shape[i][31:16]);
        end
        $display("test duty done");
        wr(8'h34, 16'h0000);
        mem = 6'($urandom) | 6'h01;
        wr(8'h50, 16'(mem));
        wr(8'h40, 16'h1fff);
        repeat (2 * PER) @(posedge I_MCLK);
        #1 chk(16'(O_PWM), 16'(mem));
        for (int k = 0; k < N_CH; k++) rdc(8'h48 + k);
        rd(8'h51, v);
        chk(v, 16'(mem));
        rdc(8'h40);
        $display("test group done");
        wrap_up();
    end

endmodule : ldui_top_tb
